// file: verilog/tsi_map.svh
`ifndef TSI_MAP_SVH
`define TSI_MAP_SVH
// ----------------------------------------------------------------
// Vector addresses, enable bit positions, reset values
// ----------------------------------------------------------------
`define TSI_VEC_EXT      10'h010
`define TSI_VEC_TMR      10'h020
`define TSI_VEC_SIO      10'h030
`define TSI_EN_EXT_BIT   0
`define TSI_EN_TMR_BIT   1
`define TSI_EN_SIO_BIT   2
`define TSI_EN_RST       3'h0
`define TSI_FLAG_RST     3'h0
`define TSI_NUM_SRC      3
`endif

// file: verilog/tsi_pkg.sv
package tsi_pkg;
   // Saved processor context, pushed on accept and popped on return
   typedef struct packed {
      logic [9:0] pc;
      logic [3:0] acc;
      logic [3:0] x;
      logic [3:0] xp;
      logic [3:0] yp;
      logic [3:0] page;
      logic [3:0] status;
   } tsi_ctx_t;

   // Sequencer states
   typedef enum logic [3:0] {
      TSI_IDLE   = 4'b0001,
      TSI_SAVE   = 4'b0010,
      TSI_SERVE  = 4'b0100,
      TSI_RESTOR = 4'b1000
   } tsi_state_t;
endpackage

// file: verilog/tsi_req_flag.sv
`timescale 1ns/100ps
// One request flag: set by its event only while enabled, set wins over clear
module tsi_req_flag (
   input  wire logic ref_clk_i,  // Machine clock
   input  wire logic srst_i,     // Sync reset, active high
   input  wire logic enable_i,   // Source enable bit
   input  wire logic event_i,    // One-cycle source event
   input  wire logic clear_i,    // Clear request
   output logic      flag_o      // Pending request
);
   // Flag register
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         flag_o <= 1'b0;
      end else if (event_i && enable_i) begin
         flag_o <= 1'b1;
      end else if (clear_i) begin
         flag_o <= 1'b0;
      end
   end
endmodule

// file: verilog/tsi_core.sv
`timescale 1ns/100ps
`include "tsi_map.svh"
module tsi_core (
   input  wire logic             ref_clk_i,      // Machine-cycle clock
   input  wire logic             srst_i,         // External reset, active high
   input  wire logic             ctrl_we_i,      // Write to interrupt control register
   input  wire logic [2:0]       ctrl_wdata_i,   // Enables: b0 ext, b1 timer, b2 serial
   input  wire logic             ext_pin_i,      // External interrupt input pin
   input  wire logic             tmr_ovf_i,      // Timer overflow event pulse
   input  wire logic             tmr_start_i,    // Timer start control pulse
   input  wire logic             sio_end_i,      // Serial transfer end event pulse
   input  wire logic             halt_i,         // Halt standby active
   input  wire logic             insn_bound_i,   // Instruction boundary strobe
   input  wire logic             return_from_interrupt_instruction_i,         // Return instruction executed
   input  wire tsi_pkg::tsi_ctx_t cur_ctx_i,     // Live processor context
   input  wire tsi_pkg::tsi_ctx_t stk_ctx_i,     // Context popped from stack
   output logic                  push_o,         // Push context to stack, pulse
   output tsi_pkg::tsi_ctx_t     push_ctx_o,     // Context being pushed
   output logic                  pop_o,          // Pop context from stack, pulse
   output logic                  pc_load_o,      // Load PC, pulse
   output logic [9:0]            pc_val_o,       // New PC value
   output tsi_pkg::tsi_ctx_t     restore_ctx_o,  // Context to restore on return
   output logic                  restore_o,      // Restore registers, pulse
   output logic                  in_service_o,   // Service routine running
   output logic [2:0]            ctrl_rdata_o,   // Enable bits read back
   output logic [2:0]            pending_o       // Request flags
);
   import tsi_pkg::*;

   // ----------------------------------------------------------------
   // Control register and edge detect
   // ----------------------------------------------------------------
   logic       [2:0] enable_q;
   logic             ext_pin_q;
   logic       [2:0] flag;
   logic       [2:0] evt;
   logic       [2:0] clr;
   logic       [1:0] served_q;
   tsi_state_t       state_q;

   // Enable bits steer flag setting
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         enable_q <= `TSI_EN_RST;
      end else if (ctrl_we_i) begin
         enable_q <= ctrl_wdata_i;
      end
   end

   // Pin history; kept running in standby so an edge there still counts
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ext_pin_q <= 1'b0;
      end else begin
         ext_pin_q <= ext_pin_i;
      end
   end

   // Event vector; external edge is latched even in halt
   always_comb begin
      evt    = 3'h0;
      evt[`TSI_EN_EXT_BIT] = ext_pin_i & ~ext_pin_q;
      evt[`TSI_EN_TMR_BIT] = tmr_ovf_i;
      evt[`TSI_EN_SIO_BIT] = sio_end_i;
   end

   // Clears: return clears the served flag; timer start also clears timer flag
   always_comb begin
      clr = 3'h0;
      if (return_from_interrupt_instruction_i && state_q == TSI_SERVE) begin
         // Decoded per source so no code can reach past the three flags
         case (served_q)
            2'h0: clr[`TSI_EN_EXT_BIT] = 1'b1;
            2'h1: clr[`TSI_EN_TMR_BIT] = 1'b1;
            2'h2: clr[`TSI_EN_SIO_BIT] = 1'b1;
            default: clr = 3'h0;
         endcase
      end
      clr[`TSI_EN_TMR_BIT] = clr[`TSI_EN_TMR_BIT] | tmr_start_i;
   end

   // ----------------------------------------------------------------
   // Request flags
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `TSI_NUM_SRC; gi = gi + 1) begin : g_flag
         tsi_req_flag u_flag (
            .ref_clk_i (ref_clk_i),
            .srst_i    (srst_i),
            .enable_i  (enable_q[gi]),
            .event_i   (evt[gi]),
            .clear_i   (clr[gi]),
            .flag_o    (flag[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Priority selection
   // ----------------------------------------------------------------
   logic [2:0] live;
   logic       take;
   logic [1:0] pick;
   logic [9:0] vec;

   // Only enabled flags compete; disabling during service masks a pending request but its flag stays set
   assign live = flag & enable_q;
   assign take = (state_q == TSI_IDLE) && insn_bound_i && !halt_i && (live != 3'h0);

   always_comb begin
      pick = 2'h0;
      vec  = `TSI_VEC_EXT;
      if (live[`TSI_EN_EXT_BIT]) begin
         pick = 2'h0;
         vec  = `TSI_VEC_EXT;
      end else if (live[`TSI_EN_TMR_BIT]) begin
         pick = 2'h1;
         vec  = `TSI_VEC_TMR;
      end else if (live[`TSI_EN_SIO_BIT]) begin
         pick = 2'h2;
         vec  = `TSI_VEC_SIO;
      end
   end

   // ----------------------------------------------------------------
   // Service sequencer
   // ----------------------------------------------------------------
   logic [9:0] vec_q;

   // Save takes one cycle, vector load the next; return pops one cycle, restores the next
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_q  <= TSI_IDLE;
         served_q <= 2'h0;
         vec_q    <= 10'h000;
      end else begin
         case (state_q)
            TSI_IDLE: begin
               if (take) begin
                  state_q  <= TSI_SAVE;
                  served_q <= pick;
                  vec_q    <= vec;
               end
            end
            TSI_SAVE: begin
               state_q <= TSI_SERVE;
            end
            TSI_SERVE: begin
               if (return_from_interrupt_instruction_i) begin
                  state_q <= TSI_RESTOR;
               end
            end
            TSI_RESTOR: begin
               state_q <= TSI_IDLE;
            end
            default: begin
               state_q <= TSI_IDLE;
            end
         endcase
      end
   end

   // Stack and PC strobes, all registered
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         push_o        <= 1'b0;
         push_ctx_o    <= '0;
         pop_o         <= 1'b0;
         pc_load_o     <= 1'b0;
         pc_val_o      <= 10'h000;
         restore_o     <= 1'b0;
         restore_ctx_o <= '0;
      end else begin
         push_o    <= take;
         pop_o     <= (state_q == TSI_SERVE) && return_from_interrupt_instruction_i;
         pc_load_o <= (state_q == TSI_SAVE);
         restore_o <= (state_q == TSI_RESTOR);
         if (take) begin
            push_ctx_o <= cur_ctx_i;
         end
         if (state_q == TSI_SAVE) begin
            pc_val_o <= vec_q;
         end
         if (state_q == TSI_RESTOR) begin
            restore_ctx_o <= stk_ctx_i;
            pc_val_o      <= stk_ctx_i.pc;
         end
      end
   end

   // Status outputs
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         in_service_o <= 1'b0;
         ctrl_rdata_o <= 3'h0;
         pending_o    <= 3'h0;
      end else begin
         in_service_o <= (state_q != TSI_IDLE) || take;
         ctrl_rdata_o <= enable_q;
         pending_o    <= flag;
      end
   end
endmodule

// file: bench/tsi_core_asserts.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checks of the interrupt unit
// ----------------------------------------
module tsi_core_asserts (
   input wire logic              ref_clk_i,     // Clock
   input wire logic              srst_i,        // Reset
   input wire logic              insn_bound_i,  // Boundary
   input wire logic              halt_i,        // Standby
   input wire logic              return_from_interrupt_instruction_i,        // Return
   input wire tsi_pkg::tsi_ctx_t cur_ctx_i,     // Live context
   input wire logic              push_o,        // Push
   input wire tsi_pkg::tsi_ctx_t push_ctx_o,    // Pushed
   input wire logic              pop_o,         // Pop
   input wire logic              pc_load_o,     // Load
   input wire logic [9:0]        pc_val_o,      // New PC
   input wire tsi_pkg::tsi_ctx_t restore_ctx_o, // Restored
   input wire logic              restore_o,     // Restore
   input wire logic              in_service_o,  // Serving
   input wire logic [2:0]        ctrl_rdata_o,  // Enables
   input wire logic [2:0]        pending_o      // Flags
);
   import tsi_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   // Accept and return each run as two steps
   sequence s_load; ##1 pc_load_o; endsequence
   sequence s_back; ##[1:2] restore_o; endsequence
   // Open from a push until its restore; a new accept may follow the restore at once
   logic busy_q;
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         busy_q <= 1'b0;
      end else if (push_o) begin
         busy_q <= 1'b1;
      end else if (restore_o) begin
         busy_q <= 1'b0;
      end
   end
   chk_push_load: assert property (push_o |-> s_load)
      else $error("vector load missing after push");
   chk_pop_back: assert property (pop_o |-> s_back)
      else $error("restore missing after pop");
   chk_no_nest: assert property (push_o |-> !busy_q)
      else $error("accept during service");
   chk_busy_shown: assert property (busy_q |-> in_service_o)
      else $error("service running but not flagged");
   chk_at_bound: assert property (push_o |-> $past(insn_bound_i && !halt_i))
      else $error("accept off boundary or in standby");
   chk_gate_flags: assert property ((pending_o & ~$past(pending_o) & ~$past(ctrl_rdata_o)) == 3'h0)
      else $error("disabled source set its flag");
   chk_push_ctx: assert property (push_o |-> push_ctx_o == $past(cur_ctx_i))
      else $error("wrong context pushed");
   chk_vec_set: assert property (pc_load_o |-> pc_val_o inside {10'h010, 10'h020, 10'h030})
      else $error("bad vector");
   chk_restore_pc: assert property (restore_o |-> pc_val_o == restore_ctx_o.pc)
      else $error("resume address differs from popped PC");
   chk_restore_ctx: assert property (restore_o |-> restore_ctx_o == push_ctx_o)
      else $error("restored context differs from pushed one");
   chk_return_from_interrupt_instruction_pop: assert property (return_from_interrupt_instruction_i && in_service_o |=> pop_o)
      else $error("no pop after return");
   chk_reset_clear: assert property (disable iff (1'b0) srst_i |=> !in_service_o && pending_o == 3'h0)
      else $error("state kept through reset");
endmodule
bind tsi_core tsi_core_asserts i_tsi_core_asserts (.*);

// file: bench/tsi_cpu_model.sv
`timescale 1ns/100ps
// Sequencer and one-deep stack facing the interrupt unit
module tsi_cpu_model import tsi_pkg::*; #(
   parameter tsi_ctx_t CTX0 = 34'h1_2345_6789  // Context before any service
) (
   input  wire logic     ref_clk_i,     // Clock
   input  wire logic     srst_i,        // Reset
   input  wire logic     push_o,        // Push strobe
   input  wire logic     pop_o,         // Pop strobe
   input  wire logic     restore_o,     // Restore strobe
   input  wire tsi_ctx_t push_ctx_o,    // Pushed context
   input  wire tsi_ctx_t restore_ctx_o, // Restored context
   output tsi_ctx_t      cur_ctx_i,     // Live context
   output tsi_ctx_t      stk_ctx_i,     // Stack output
   output logic          insn_bound_i   // Boundary
);
   tsi_ctx_t   stk_q;
   // Two-cycle instructions, so acceptance timing is not always immediate
   always_ff @(posedge ref_clk_i) insn_bound_i <= srst_i ? 1'b0 : ~insn_bound_i;
   // Stack keeps the context pushed at accept
   always_ff @(posedge ref_clk_i) begin
      if (push_o) stk_q <= push_ctx_o;
   end
   // Popped data stands only while the pop strobe is up, so a late sample shows
   assign stk_ctx_i = pop_o ? stk_q : ~stk_q;
   // Service routine clobbers the registers; restore brings them back
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) cur_ctx_i <= CTX0;
      else if (restore_o) cur_ctx_i <= restore_ctx_o;
      else if (push_o) cur_ctx_i <= ~push_ctx_o;
   end
endmodule

// file: bench/tsi_core_bench.sv
`timescale 1ns/100ps
module tsi_core_bench;
   import tsi_pkg::*;
   localparam tsi_ctx_t CTX0 = 34'h1_2345_6789;
   logic ref_clk_i = 0, srst_i = 1, ctrl_we_i = 0, ext_pin_i = 0, tmr_ovf_i = 0;
   logic tmr_start_i = 0, sio_end_i = 0, halt_i = 0, return_from_interrupt_instruction_i = 0, insn_bound_i;
   logic [2:0] ctrl_wdata_i = 3'h0, ctrl_rdata_o, pending_o;
   logic [9:0] pc_val_o;
   logic       push_o, pop_o, pc_load_o, restore_o, in_service_o;
   tsi_ctx_t   cur_ctx_i, stk_ctx_i, push_ctx_o, restore_ctx_o;
   int         fails = 0, num_checks = 0;
   tsi_core i_tsi_core (.*);
   tsi_cpu_model #(.CTX0(CTX0)) i_tsi_cpu_model (.*);
   always #2.5 ref_clk_i = ~ref_clk_i;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task stop_test;
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task cmp(input logic [33:0] g, input logic [33:0] e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   // Event k: 0 pin edge, 1 overflow, 2 serial end, 3 timer start
   task pulse(input int k);
      tick(1);
      case (k)
         0: ext_pin_i = 1;
         1: tmr_ovf_i = 1;
         2: sio_end_i = 1;
         default: tmr_start_i = 1;
      endcase
      tick(1);
      {ext_pin_i, tmr_ovf_i, sio_end_i, tmr_start_i} = 4'h0;
      tick(2);
   endtask
   task set_en(input logic [2:0] v);
      tick(1);
      ctrl_we_i = 1;
      ctrl_wdata_i = v;
      tick(1);
      ctrl_we_i = 0;
      tick(1);
      cmp(ctrl_rdata_o, v);
   endtask
   // Wait for the vector, return, and see the context come back whole
   task serve(input logic [9:0] v);
      repeat (20) if (pc_load_o !== 1'b1) tick(1);
      cmp(pc_val_o, v);
      tick(1);
      return_from_interrupt_instruction_i = 1;
      tick(1);
      return_from_interrupt_instruction_i = 0;
      repeat (9) if (restore_o !== 1'b1) tick(1);
      tick(1);
      cmp(cur_ctx_i, CTX0);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_single;
      set_en(3'h7);
      for (int k = 0; k < 3; k++) begin
         pulse(k);
         serve(10'(16 * (k + 1)));
         cmp(pending_o, 3'h0);
      end
   endtask
   // All three raised in standby, then served one by one in order
   task t_prio;
      halt_i = 1;
      pulse(2);
      pulse(1);
      pulse(0);
      cmp(pending_o, 3'h7);
      halt_i = 0;
      serve(10'h010);
      cmp(pending_o, 3'h6);
      serve(10'h020);
      serve(10'h030);
   endtask
   task t_gate;
      set_en(3'h0);
      for (int k = 0; k < 3; k++) pulse(k);
      cmp(pending_o, 3'h0);
      set_en(3'h7);
      tick(4);
      cmp(in_service_o, 1'b0);
      halt_i = 1;
      pulse(1);
      cmp(pending_o, 3'h2);
      pulse(3);
      cmp(pending_o, 3'h0);
      halt_i = 0;
   endtask
   initial begin
      tick(8);
      cmp({in_service_o, pending_o}, 4'h0);
      srst_i = 0;
      tick(2);
      t_single();
      t_prio();
      t_gate();
      stop_test();
   end
   // Whole run needs roughly a hundred cycles
   initial begin
      repeat (3000) @(posedge ref_clk_i);
      fails++;
      stop_test();
   end
endmodule
